// ==== rtl/tpg_pkg.sv ====
// Shared constants and types of the test pattern generator
package tpg_pkg;

    // ----------------------------------------------------------------
    // Command port word addresses
    // ----------------------------------------------------------------
    localparam logic TPG_COMMAND_LOW_WORD = 1'b0;
    localparam logic TPG_COMMAND_HIGH_WORD = 1'b1;

    // Command low word fields: symbol count, channel, packet marks
    localparam int TPG_CMD_CNT_LSB = 0;
    localparam int TPG_CMD_CH_LSB = 16;
    localparam int TPG_CMD_SOP_BIT = 24;
    localparam int TPG_CMD_EOP_BIT = 25;
    // Command high word fields: data error mask, error signal value
    localparam int TPG_HI_MASK_LSB = 0;
    localparam int TPG_HI_ERR_LSB = 16;

    // ----------------------------------------------------------------
    // Control and status register indices (word addresses)
    // ----------------------------------------------------------------
    localparam logic [1:0] TPG_CSR_STATUS = 2'h0;
    localparam logic [1:0] TPG_CSR_CONTROL = 2'h1;
    localparam logic [1:0] TPG_CSR_FILL = 2'h2;

    // Control fields and reset value
    localparam int TPG_CTL_EN_BIT = 0;
    localparam int TPG_CTL_THR_LSB = 8;
    localparam int TPG_CTL_THR_MSB = 16;
    localparam int TPG_CTL_SRST_BIT = 17;
    localparam logic [31:0] TPG_CTL_WMASK = 32'h0003_FF01;
    localparam logic [31:0] TPG_CTL_RESET = 32'h0000_0000;

    // Status fields
    localparam int TPG_ST_ID_LSB = 0;
    localparam int TPG_ST_NCH_LSB = 16;
    localparam int TPG_ST_NSYM_LSB = 24;
    localparam int TPG_ST_PKT_BIT = 31;
    localparam int TPG_FILL_BUSY_BIT = 0;

    // ----------------------------------------------------------------
    // Sizes and generator constants
    // ----------------------------------------------------------------
    localparam int TPG_CMD_DEPTH = 16;
    localparam int TPG_OUT_DEPTH = 4;
    localparam int TPG_POS_W = 16;
    localparam logic [15:0] TPG_LFSR_TAPS = 16'hB400;
    localparam logic [15:0] TPG_POS_RESET = 16'h0000;

    // Generator sequencing
    typedef enum logic {GEN_IDLE, GEN_RUN} tpg_gen_state_t;

endpackage

// ==== rtl/tpg_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides and a synchronous flush
`timescale 1ns/1ps
module tpg_fifo
    import tpg_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_clr,
    // Fill side
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    // Drain side
    output logic [WIDTH-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready
);

    localparam int PW = $clog2(DEPTH);

    // Pointers wrap naturally only for powers of two; refused at elaboration
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("tpg_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    // Honest flags straight from the occupancy count
    assign o_ready = (cnt_q != (PW+1)'(DEPTH));
    assign o_valid = (cnt_q != '0);
    assign o_data = mem_q[rd_q];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    // ----------------------------------------------------------------
    // Pointers and count
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (i_clr) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + PW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + PW'(1);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + (PW+1)'(1);
            end else if (pop && !push) begin
                cnt_q <= cnt_q - (PW+1)'(1);
            end
        end
    end

    // Storage needs no reset; only counted entries are ever read
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_q[wr_q] <= i_data;
        end
    end

endmodule

// ==== rtl/tpg_top.sv ====
// Test pattern generator: command port, control/status port, stream out
// What this block does
// - Each symbol equals its packet position XOR the programmed data error mask.
// - Without packet support the stream never starts or ends; positions keep advancing.
// - 32-bit write-only command port feeds a sixteen-entry command FIFO.
// - Only a write to word address 0 pushes a command.
// - Wait-request is high while the command FIFO is full.
// - Writing zero to the high word or its fields removes the errors.
// - Throttle value and a pseudo-random number decide each beat.
// - The pseudo-random generator starts from a build-time seed parameter.
// - A 32-bit control/status port enables generation and sets the throttle.
// - Status returns build-time channel count and packet support.
// - Each channel keeps its own symbol position for interleaved fragments.
// - Channel count is a parameter from 1 to 256; channel port sized to it.
// - Symbols per beat is a parameter from 1 to 256.
// - Data width must be a multiple of bits per symbol, else error.
// - Packet mark and empty count ports always exist; without packet support they stay zero.
// - Error signal width is 0 to 31; zero leaves it unused.
// - Control bit 0 enables the generator.
// - Throttle in control bits 16:8: 0 stops, 256 full rate.
// - Control bit 17 holds all counters in reset until cleared.
// - Status holds identifier, channel count, symbols per beat, packet flag.
`timescale 1ns/1ps
module tpg_top
    import tpg_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int BPS = 8,
    parameter int NCH = 1,
    parameter bit PKT = 1'b1,
    parameter int ERR_W = 1,
    parameter logic [15:0] SEED = 16'h1234,
    parameter logic [15:0] DEV_ID = 16'h00A5, // Arbitrary identifier value
    localparam int NSYM = DATA_W / BPS,
    localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1,
    localparam int EMW = (NSYM > 1) ? $clog2(NSYM) : 1,
    localparam int EW = (ERR_W > 0) ? ERR_W : 1
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Command port (write only)
    input wire logic i_cmd_address,
    input wire logic i_cmd_write,
    input wire logic [31:0] i_cmd_writedata,
    output logic o_cmd_waitrequest,
    // Control and status port
    input wire logic [1:0] i_csr_address,
    input wire logic i_csr_read,
    input wire logic i_csr_write,
    input wire logic [31:0] i_csr_writedata,
    output logic [31:0] o_csr_readdata,
    // Stream output
    output logic o_st_valid,
    input wire logic i_st_ready,
    output logic [DATA_W-1:0] o_st_data,
    output logic [CHW-1:0] o_st_channel,
    output logic o_st_sop,
    output logic o_st_eop,
    output logic [EMW-1:0] o_st_empty,
    output logic [EW-1:0] o_st_error
);

    // ----------------------------------------------------------------
    // Build-time checks
    // ----------------------------------------------------------------
    // Refused at elaboration, so a bad build never reaches simulation
    if (BPS < 1 || BPS > 16 || (DATA_W % BPS) != 0) begin : g_bad_bps
        $error("tpg_top: DATA_W must be a multiple of BPS (1..16)");
    end
    if (NSYM < 1 || NSYM > 256) begin : g_bad_nsym
        $error("tpg_top: symbols per beat must be 1..256");
    end
    if (NCH < 1 || NCH > 256) begin : g_bad_nch
        $error("tpg_top: channel count must be 1..256");
    end
    if (ERR_W < 0 || ERR_W > 31) begin : g_bad_errw
        $error("tpg_top: error width must be 0..31");
    end
    if (SEED == 16'h0000) begin : g_bad_seed
        $error("tpg_top: seed must be nonzero");
    end

    localparam int OFW = DATA_W + CHW + 2 + EMW + EW;
    localparam logic [15:0] NSYM16 = 16'(NSYM);

    // Symbol value: position plus offset, XOR the error mask
    function automatic logic [BPS-1:0] sym_val(input logic [15:0] base,
                                               input logic [15:0] idx,
                                               input logic [15:0] mask);
        logic [15:0] p;
        p = base + idx;
        return p[BPS-1:0] ^ mask[BPS-1:0];
    endfunction

    // ----------------------------------------------------------------
    // Control register and soft reset
    // ----------------------------------------------------------------
    logic [31:0] ctl_q;
    logic ctl_en;
    logic [8:0] ctl_thr;
    logic srst;

    assign ctl_en = ctl_q[TPG_CTL_EN_BIT];
    assign ctl_thr = ctl_q[TPG_CTL_THR_MSB:TPG_CTL_THR_LSB];
    assign srst = ctl_q[TPG_CTL_SRST_BIT];

    // Reserved control bits are masked so they read back as zero
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctl_q <= TPG_CTL_RESET;
        end else if (i_csr_write && i_csr_address == TPG_CSR_CONTROL) begin
            ctl_q <= i_csr_writedata & TPG_CTL_WMASK;
        end
    end

    // ----------------------------------------------------------------
    // Command port and command FIFO
    // ----------------------------------------------------------------
    logic [31:0] hi_q;
    logic cf_ready;
    logic cf_valid;
    logic cf_pop;
    logic cmd_push;
    logic [63:0] cf_data;

    // Stall by wait-request; the master holds the write meanwhile
    assign o_cmd_waitrequest = !cf_ready;
    assign cmd_push = i_cmd_write && i_cmd_address == TPG_COMMAND_LOW_WORD && cf_ready;

    // High word rides along with every later command; zero clears errors
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hi_q <= 32'h0000_0000;
        end else if (i_cmd_write && i_cmd_address == TPG_COMMAND_HIGH_WORD) begin
            hi_q <= i_cmd_writedata;
        end
    end

    tpg_fifo #(.WIDTH(64), .DEPTH(TPG_CMD_DEPTH)) u_cmd_fifo (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_clr(srst),
        .i_data({hi_q, i_cmd_writedata}),
        .i_valid(cmd_push),
        .o_ready(cf_ready),
        .o_data(cf_data),
        .o_valid(cf_valid),
        .i_ready(cf_pop)
    );

    // ----------------------------------------------------------------
    // Throttle pseudo-random source
    // ----------------------------------------------------------------
    logic [15:0] lfsr_q;
    logic thr_ok;

    // Free-running Galois register restarted from the seed
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lfsr_q <= SEED;
        end else if (srst) begin
            lfsr_q <= SEED;
        end else begin
            lfsr_q <= {1'b0, lfsr_q[15:1]} ^ (lfsr_q[0] ? TPG_LFSR_TAPS : 16'h0000);
        end
    end

    // 0 never passes, 256 always passes, between is proportional
    assign thr_ok = {1'b0, lfsr_q[7:0]} < ctl_thr;

    // ----------------------------------------------------------------
    // Generator sequencing
    // ----------------------------------------------------------------
    tpg_gen_state_t st_q;
    logic [15:0] rem_q;
    logic [CHW-1:0] ch_q;
    logic sop_q;
    logic eop_q;
    logic first_q;
    logic [31:0] ghi_q;
    logic [TPG_POS_W-1:0] pos_q [NCH];
    logic of_ready;
    logic gen_fire;
    logic last_beat;
    logic [15:0] take_n;
    logic [15:0] base;
    logic [7:0] cmd_ch;

    assign cmd_ch = cf_data[TPG_CMD_CH_LSB +: 8];
    assign cf_pop = (st_q == GEN_IDLE) && cf_valid && !srst;
    assign gen_fire = (st_q == GEN_RUN) && ctl_en && thr_ok && of_ready && !srst;
    assign last_beat = rem_q <= NSYM16;
    assign take_n = last_beat ? rem_q : NSYM16;
    // A new packet restarts at zero; otherwise the channel carries on
    assign base = (PKT && first_q && sop_q) ? TPG_POS_RESET : pos_q[ch_q];

    // Commands are taken one at a time in arrival order
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q <= GEN_IDLE;
            rem_q <= 16'h0000;
            ch_q <= '0;
            sop_q <= 1'b0;
            eop_q <= 1'b0;
            first_q <= 1'b0;
            ghi_q <= 32'h0000_0000;
        end else if (srst) begin
            st_q <= GEN_IDLE;
            rem_q <= 16'h0000;
            first_q <= 1'b0;
        end else begin
            unique case (st_q)
                GEN_IDLE: begin
                    if (cf_valid) begin
                        rem_q <= cf_data[TPG_CMD_CNT_LSB +: 16];
                        // Channels past the configured count fold onto channel 0
                        ch_q <= (32'(cmd_ch) < NCH) ? CHW'(cmd_ch) : '0;
                        sop_q <= cf_data[TPG_CMD_SOP_BIT];
                        eop_q <= cf_data[TPG_CMD_EOP_BIT];
                        ghi_q <= cf_data[63:32];
                        first_q <= 1'b1;
                        if (cf_data[TPG_CMD_CNT_LSB +: 16] != 16'h0000) begin
                            st_q <= GEN_RUN;
                        end
                    end
                end
                GEN_RUN: begin
                    if (gen_fire) begin
                        rem_q <= rem_q - take_n;
                        first_q <= 1'b0;
                        if (last_beat) begin
                            st_q <= GEN_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Per-channel position, cleared by either reset
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int c = 0; c < NCH; c++) begin
                pos_q[c] <= TPG_POS_RESET;
            end
        end else if (srst) begin
            for (int c = 0; c < NCH; c++) begin
                pos_q[c] <= TPG_POS_RESET;
            end
        end else if (gen_fire) begin
            pos_q[ch_q] <= base + take_n;
        end
    end

    // ----------------------------------------------------------------
    // Beat assembly into the output FIFO
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] gen_data;
    logic gen_sop;
    logic gen_eop;
    logic [EMW-1:0] gen_empty;
    logic [EW-1:0] gen_err;
    logic [31:0] err32;
    logic [OFW-1:0] of_data;

    // First symbol in the most significant lane; unused lanes are zero
    always_comb begin
        gen_data = '0;
        for (int i = 0; i < NSYM; i++) begin
            if (16'(i) < take_n) begin
                gen_data[DATA_W-1-i*BPS -: BPS] = sym_val(base, 16'(i),
                                                          ghi_q[TPG_HI_MASK_LSB +: 16]);
            end
        end
    end

    assign gen_sop = PKT && first_q && sop_q;
    assign gen_eop = PKT && last_beat && eop_q;
    assign gen_empty = gen_eop ? EMW'(NSYM16 - take_n) : '0;
    assign err32 = {16'h0000, ghi_q[TPG_HI_ERR_LSB +: 16]};
    assign gen_err = (ERR_W > 0) ? err32[EW-1:0] : '0;

    // Small buffer decouples sink stalls from the throttle decision
    tpg_fifo #(.WIDTH(OFW), .DEPTH(TPG_OUT_DEPTH)) u_out_fifo (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_clr(srst),
        .i_data({gen_data, ch_q, gen_sop, gen_eop, gen_empty, gen_err}),
        .i_valid(gen_fire),
        .o_ready(of_ready),
        .o_data(of_data),
        .o_valid(o_st_valid),
        .i_ready(i_st_ready)
    );

    assign {o_st_data, o_st_channel, o_st_sop, o_st_eop, o_st_empty, o_st_error} = of_data;

    // ----------------------------------------------------------------
    // Control and status read path
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;
    logic busy;

    assign busy = (st_q == GEN_RUN) || cf_valid || o_st_valid;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (i_csr_address)
            TPG_CSR_STATUS: begin
                rd_mux[TPG_ST_ID_LSB +: 16] = DEV_ID;
                rd_mux[TPG_ST_NCH_LSB +: 8] = 8'(NCH);
                rd_mux[TPG_ST_NSYM_LSB +: 7] = 7'(NSYM);
                rd_mux[TPG_ST_PKT_BIT] = PKT;
            end
            TPG_CSR_CONTROL: rd_mux = ctl_q;
            TPG_CSR_FILL: rd_mux[TPG_FILL_BUSY_BIT] = busy;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data appears one cycle after the read strobe
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_csr_readdata <= 32'h0000_0000;
        end else if (i_csr_read) begin
            o_csr_readdata <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    sequence s_lo_write;
        i_cmd_write && i_cmd_address == TPG_COMMAND_LOW_WORD;
    endsequence
    sequence s_hi_write;
        i_cmd_write && i_cmd_address == TPG_COMMAND_HIGH_WORD;
    endsequence
    // Checks watch the FIFO flags and outputs, plus internal terms such as srst, hi_q, st_q and gen_fire
    AST_WAIT_WHEN_FULL: assert property ($rose(o_cmd_waitrequest) |-> $past(cmd_push))
        else $error("command FIFO became full without a push");
    AST_LO_PUSHES: assert property (
        s_lo_write and !o_cmd_waitrequest && !srst |=> cf_valid)
        else $error("low word write did not reach the command FIFO");
    AST_HI_NO_PUSH: assert property (s_hi_write and !cf_valid |=> !cf_valid)
        else $error("high word write pushed a command");
    AST_HI_LATCH: assert property (s_hi_write |=> hi_q == $past(i_cmd_writedata))
        else $error("high word not captured");
    AST_DISABLED_IDLE: assert property (!ctl_en && !o_st_valid |=> !o_st_valid)
        else $error("beat produced while disabled");
    AST_THR_ZERO: assert property (ctl_thr == 9'h000 && !o_st_valid |=> !o_st_valid)
        else $error("beat produced at throttle zero");
    AST_SRST_CLEAR: assert property (
        srst |=> st_q == GEN_IDLE && rem_q == 16'h0000 && !o_st_valid)
        else $error("soft reset did not clear state");
    AST_SOP_IS_MASK: assert property (
        gen_fire && gen_sop |->
            gen_data[DATA_W-1 -: BPS] == ghi_q[BPS-1:0])
        else $error("first symbol of packet is not the mask");
    AST_NO_MARKS: assert property (!PKT |-> !o_st_sop && !o_st_eop)
        else $error("packet marks without packet support");
    AST_OUT_HOLD: assert property (
        o_st_valid && !i_st_ready && !srst |=> o_st_valid && $stable(o_st_data))
        else $error("output dropped under back-pressure");

endmodule

// ==== verif/tpg_sink_model.sv ====
// Streaming sink model standing in for the consumer downstream of the generator
`timescale 1ns/1ps
module tpg_sink_model (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Pacing choice and handshake
    input wire logic i_slow,
    output logic o_ready
);
    // ------------------------------------------------
    // Ready pacing
    // ------------------------------------------------
    // Slow mode drops ready every other cycle, so beats must hold
    always @(negedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_ready <= 1'b0;
        end else begin
            o_ready <= i_slow ? ~o_ready : 1'b1;
        end
    end
endmodule

// ==== verif/tpg_top_tb.sv ====
// Self-checking testbench of the test pattern generator
`timescale 1ns/1ps
module tpg_top_tb;
    import tpg_pkg::*;
    localparam logic [15:0] ID = 16'h5A3C; // Arbitrary identifier value
    logic i_mclk, i_sys_rst, i_cmd_address, i_cmd_write, i_csr_read, i_csr_write;
    logic slow, o_cmd_waitrequest, o_st_valid, i_st_ready, o_st_sop, o_st_eop;
    logic o_st_channel, o_st_error;
    logic [1:0] i_csr_address, o_st_empty;
    logic [31:0] i_cmd_writedata, i_csr_writedata, o_csr_readdata, o_st_data, rd;
    logic [37:0] beats[$];
    int errors = 0;
    int total_checks = 0;

    tpg_top #(.NCH(2), .DEV_ID(ID)) uut (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_cmd_address(i_cmd_address), .i_cmd_write(i_cmd_write),
        .i_cmd_writedata(i_cmd_writedata), .o_cmd_waitrequest(o_cmd_waitrequest),
        .i_csr_address(i_csr_address), .i_csr_read(i_csr_read),
        .i_csr_write(i_csr_write), .i_csr_writedata(i_csr_writedata),
        .o_csr_readdata(o_csr_readdata), .o_st_valid(o_st_valid),
        .i_st_ready(i_st_ready), .o_st_data(o_st_data), .o_st_channel(o_st_channel),
        .o_st_sop(o_st_sop), .o_st_eop(o_st_eop), .o_st_empty(o_st_empty),
        .o_st_error(o_st_error));
    tpg_sink_model sink (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_slow(slow),
        .o_ready(i_st_ready));

    // ------------------------------------------------
    // Clock, beat monitor, shared tasks
    // ------------------------------------------------
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    // Sampled on the rising edge, before the design's own updates land
    always @(posedge i_mclk) begin
        if (o_st_valid === 1'b1 && i_st_ready === 1'b1) begin
            beats.push_back({o_st_data, o_st_sop, o_st_eop, o_st_empty, o_st_channel,
                o_st_error});
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held until the edge that sees wait-request low
    task automatic cmd_wr(input logic a, input logic [31:0] d);
        @(negedge i_mclk);
        i_cmd_address = a;
        i_cmd_write = 1'b1;
        i_cmd_writedata = d;
        while (o_cmd_waitrequest !== 1'b0) @(negedge i_mclk);
        @(negedge i_mclk);
        i_cmd_write = 1'b0;
    endtask
    task automatic csr_wr(input logic [1:0] a, input logic [31:0] d);
        @(negedge i_mclk);
        i_csr_address = a;
        i_csr_write = 1'b1;
        i_csr_writedata = d;
        @(negedge i_mclk);
        i_csr_write = 1'b0;
    endtask
    task automatic csr_rd(input logic [1:0] a, output logic [31:0] d);
        @(negedge i_mclk);
        i_csr_address = a;
        i_csr_read = 1'b1;
        @(negedge i_mclk);
        i_csr_read = 1'b0;
        d = o_csr_readdata;
    endtask
    // Side fields: {sop, eop, empty, channel, error}; lanes past empty are ignored
    task automatic beat_chk(input int n, input logic [7:0] pos, input logic [7:0] msk,
                            input logic [5:0] side);
        logic [31:0] exp;
        logic [31:0] care;
        for (int s = 0; s < 4; s++) begin
            exp[31-8*s -: 8] = (pos + 8'(s)) ^ msk;
            care[31-8*s -: 8] = (s < 4 - side[3:2]) ? 8'hFF : 8'h00;
        end
        chk("beat data", exp & care, beats[n][37:6] & care);
        chk("beat marks", {26'h0, side}, {26'h0, beats[n][5:0]});
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_regs();
        csr_rd(TPG_CSR_STATUS, rd);
        chk("status", {1'b1, 7'h4, 8'h2, ID}, rd);
        csr_wr(TPG_CSR_CONTROL, 32'hFFFF_FFFF);
        csr_rd(TPG_CSR_CONTROL, rd);
        chk("control", 32'h0003_FF01, rd);
        csr_wr(TPG_CSR_CONTROL, 32'h0000_0000);
        csr_rd(2'h3, rd);
        chk("unmapped", 32'h0000_0000, rd);
        $display("test regs done");
    endtask
    task automatic t_fill();
        for (int i = 0; i < 20; i++) cmd_wr(TPG_COMMAND_HIGH_WORD, 32'h0000_0000);
        chk("wait after high writes", 32'h0, {31'h0, o_cmd_waitrequest});
        // The idle generator takes the first command, so one more fills the FIFO
        for (int i = 0; i < TPG_CMD_DEPTH + 1; i++) cmd_wr(TPG_COMMAND_LOW_WORD, 32'h0000_0001);
        @(negedge i_mclk);
        chk("wait when full", 32'h1, {31'h0, o_cmd_waitrequest});
        csr_rd(TPG_CSR_FILL, rd);
        chk("fill busy", 32'h1, rd & 32'h1);
        csr_wr(TPG_CSR_CONTROL, 32'h0002_0000);
        csr_wr(TPG_CSR_CONTROL, 32'h0000_0000);
        chk("wait after soft reset", 32'h0, {31'h0, o_cmd_waitrequest});
        csr_rd(TPG_CSR_FILL, rd);
        chk("fill after soft reset", 32'h0, rd);
        $display("test fill done");
    endtask
    // Interleaved channels with a stalling sink; mask set then cleared
    task automatic t_stream();
        slow = 1'b1;
        cmd_wr(TPG_COMMAND_HIGH_WORD, 32'h0001_0055);
        cmd_wr(TPG_COMMAND_LOW_WORD, 32'h0300_0006);
        cmd_wr(TPG_COMMAND_HIGH_WORD, 32'h0000_0000);
        cmd_wr(TPG_COMMAND_LOW_WORD, 32'h0101_0004);
        cmd_wr(TPG_COMMAND_LOW_WORD, 32'h0100_0008);
        cmd_wr(TPG_COMMAND_LOW_WORD, 32'h0201_0004);
        beats.delete();
        csr_wr(TPG_CSR_CONTROL, 32'h0001_0001);
        for (int i = 0; i < 100 && beats.size() < 6; i++) @(negedge i_mclk);
        chk("beat count", 32'h6, beats.size());
        beat_chk(0, 8'h0, 8'h55, 6'h21);
        beat_chk(1, 8'h4, 8'h55, 6'h19);
        beat_chk(2, 8'h0, 8'h00, 6'h22);
        beat_chk(3, 8'h0, 8'h00, 6'h20);
        beat_chk(4, 8'h4, 8'h00, 6'h00);
        beat_chk(5, 8'h4, 8'h00, 6'h12);
        csr_wr(TPG_CSR_CONTROL, 32'h0000_0000);
        slow = 1'b0;
        $display("test stream done");
    endtask
    task automatic t_throttle();
        beats.delete();
        cmd_wr(TPG_COMMAND_LOW_WORD, 32'h0300_0004);
        csr_wr(TPG_CSR_CONTROL, 32'h0000_0001);
        repeat (40) @(negedge i_mclk);
        chk("beats at throttle 0", 32'h0, beats.size());
        csr_wr(TPG_CSR_CONTROL, 32'h0000_8001);
        for (int i = 0; i < 300 && beats.size() < 1; i++) @(negedge i_mclk);
        chk("beats at half throttle", 32'h1, beats.size());
        beat_chk(0, 8'h0, 8'h00, 6'h30);
        $display("test throttle done");
    endtask

    // ------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------
    initial begin
        i_sys_rst = 1'b1;
        i_cmd_address = 1'b0;
        i_cmd_write = 1'b0;
        i_cmd_writedata = 32'h0000_0000;
        i_csr_address = 2'h0;
        i_csr_read = 1'b0;
        i_csr_write = 1'b0;
        i_csr_writedata = 32'h0000_0000;
        slow = 1'b0;
        repeat (6) @(negedge i_mclk);
        i_sys_rst = 1'b0;
        t_regs();
        t_fill();
        t_stream();
        t_throttle();
        conclude();
    end
    // All tests need well under a thousand cycles
    initial begin
        repeat (6000) @(posedge i_mclk);
        errors++;
        conclude();
    end
endmodule
